// file: design/stm_consts.svh
// Object addresses, reset values and timing constants of the timing monitor
`ifndef STM_CONSTS_SVH
`define STM_CONSTS_SVH

// ----------------------------------------------------------------------
// Object indices and subindices
// ----------------------------------------------------------------------
`define STM_IDX_OUT        16'h1c32
`define STM_IDX_IN         16'h1c33
`define STM_SUB_COUNT      8'h00
`define STM_SUB_MODE       8'h01
`define STM_SUB_CYCLE      8'h02
`define STM_SUB_SHIFT      8'h03
`define STM_SUB_MIN_CYCLE  8'h05
`define STM_SUB_CALC_COPY  8'h06
`define STM_SUB_MIN_DELAY  8'h07
`define STM_SUB_COMMAND    8'h08
`define STM_SUB_MAX_DELAY  8'h09
`define STM_SUB_MISSED     8'h0b
`define STM_SUB_OVERRUN    8'h0c
`define STM_SUB_SHORT      8'h0d
`define STM_SUB_LATE       8'h20

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define STM_MIN_CYCLE_NS   32'h000101d0
`define STM_IN_MODE_RST    16'h0022
`define STM_IN_CYCLE_RST   32'h000f4240
`define STM_IN_PARAM_CNT   8'h20
`define STM_CMD_RST        16'h0000
`define STM_CMD_START      16'h0001
`define STM_MODE_FREE      16'h0000
`define STM_MODE_SM3       16'h0001
`define STM_MODE_SYNC0     16'h0002
`define STM_MODE_SYNC1     16'h0003
`define STM_MODE_SM2       16'h0022
`define STM_CNT_MAX        16'hffff
`define STM_CNT_ONE        16'h0001

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define STM_CLK_MHZ        25
`define STM_CLK_PERIOD_NS  (1000 / `STM_CLK_MHZ)

`endif

// file: design/stm_monitor.sv
// Synchronisation timing monitor and parameter objects
// Overview of operation
// - Minimum cycle time reads 66000 ns
// - Report minimum SYNC0 to SYNC1 need, DC
// - Report minimum SYNC1 to output delay, DC
// - Command 1 starts, 0 stops measurement
// - Measuring keeps largest shift, copy, max delay values, DC
// - New start clears captured maxima first
// - Report maximum SYNC1 to output delay, DC
// - Count missed sync-manager events in run state, DC
// - Count cycle overruns in run state
// - Count too short SYNC0 to SYNC1 gaps, DC
// - Flag outputs driven too late last cycle, DC
// - Input sync mode encodings, default 0x0022
// - Input cycle time, default 1000000 ns
`timescale 1ns/1ps
`include "stm_consts.svh"

module stm_monitor (
    // Clock, reset, enable
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    input  wire logic          ce,
    // Device status
    input  wire logic          run_state,
    input  wire logic          distributed_clock_mode,
    input  wire stm_pkg::stm_evt_t evt,
    // Object access
    input  wire stm_pkg::stm_req_t req,
    output stm_pkg::stm_rsp_t  rsp_q,
    output logic               measuring
);
    import stm_pkg::*;

    // ------------------------------------------------------------------
    // Local time base
    // ------------------------------------------------------------------
    localparam logic [31:0] STEP_NS = 32'(`STM_CLK_PERIOD_NS);

    logic [31:0] now_q;
    logic [31:0] t_s0_q;
    logic [31:0] t_s1_q;
    logic [31:0] t_sm_q;
    logic        have_s0_q;
    logic        have_s1_q;
    logic        have_sm_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            now_q <= 32'h0;
        end else if (ce) begin
            now_q <= now_q + STEP_NS;
        end
    end

    // An event stamp is valid until the outputs of that cycle are driven
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            t_s0_q    <= 32'h0;
            t_s1_q    <= 32'h0;
            t_sm_q    <= 32'h0;
            have_s0_q <= 1'b0;
            have_s1_q <= 1'b0;
            have_sm_q <= 1'b0;
        end else if (ce) begin
            if (evt.sync0) begin
                t_s0_q <= now_q;
            end
            if (evt.sync1) begin
                t_s1_q <= now_q;
            end
            if (evt.sm) begin
                t_sm_q <= now_q;
            end
            have_s0_q <= evt.sync0 | (have_s0_q & ~evt.out_drive);
            have_s1_q <= evt.sync1 | (have_s1_q & ~evt.out_drive);
            have_sm_q <= evt.sm | (have_sm_q & ~evt.out_drive);
        end
    end

    logic [31:0] d_s0;
    logic [31:0] d_s1;
    logic [31:0] d_sm;
    assign d_s0 = now_q - t_s0_q;
    assign d_s1 = now_q - t_s1_q;
    assign d_sm = now_q - t_sm_q;

    // ------------------------------------------------------------------
    // Object writes
    // ------------------------------------------------------------------
    logic [23:0] addr;
    logic        wr_cmd;
    logic        wr_mode;
    logic        wr_cycle;
    logic        mode_ok;
    logic [15:0] cmd_q;
    logic [15:0] in_mode_q;
    logic [31:0] in_cycle_q;
    logic        start;

    assign addr     = {req.index, req.sub};
    assign wr_cmd   = req.wr && addr == {`STM_IDX_OUT, `STM_SUB_COMMAND};
    assign wr_mode  = req.wr && addr == {`STM_IDX_IN, `STM_SUB_MODE};
    assign wr_cycle = req.wr && addr == {`STM_IDX_IN, `STM_SUB_CYCLE};
    assign start    = ce && wr_cmd && req.wdata[15:0] == `STM_CMD_START;

    // Only the listed codes are accepted; others keep the old mode
    always_comb begin
        unique case (req.wdata[15:0])
            `STM_MODE_FREE, `STM_MODE_SM3, `STM_MODE_SYNC0,
            `STM_MODE_SYNC1, `STM_MODE_SM2: mode_ok = 1'b1;
            default:                        mode_ok = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q      <= `STM_CMD_RST;
            in_mode_q  <= `STM_IN_MODE_RST;
            in_cycle_q <= `STM_IN_CYCLE_RST;
        end else if (ce) begin
            if (wr_cmd) begin
                cmd_q <= req.wdata[15:0];
            end
            if (wr_mode && mode_ok) begin
                in_mode_q <= req.wdata[15:0];
            end
            if (wr_cycle) begin
                in_cycle_q <= req.wdata;
            end
        end
    end

    stm_meas_t meas_st;
    assign meas_st   = (cmd_q == `STM_CMD_START) ? STM_MEASURE : STM_IDLE;
    assign measuring = (meas_st == STM_MEASURE);

    // ------------------------------------------------------------------
    // Worst-case capture
    // ------------------------------------------------------------------
    logic [31:0] shift_out_q;
    logic [31:0] calc_copy_q;
    logic [31:0] min_delay_q;
    logic [31:0] max_delay_q;
    logic        upd;
    logic        upd_dc;

    assign upd    = ce && measuring && evt.out_drive;
    assign upd_dc = upd && distributed_clock_mode;

    // Clearing on start wins over an update in the same cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_out_q <= 32'h0;
            calc_copy_q <= 32'h0;
            min_delay_q <= 32'h0;
            max_delay_q <= 32'h0;
        end else if (start) begin
            shift_out_q <= 32'h0;
            calc_copy_q <= 32'h0;
            min_delay_q <= 32'h0;
            max_delay_q <= 32'h0;
        end else begin
            if (upd_dc && have_s0_q && d_s0 > shift_out_q) begin
                shift_out_q <= d_s0;
            end
            if (upd_dc && have_sm_q && d_sm > calc_copy_q) begin
                calc_copy_q <= d_sm;
            end
            if (upd_dc && have_s1_q &&
                (min_delay_q == 32'h0 || d_s1 < min_delay_q)) begin
                min_delay_q <= d_s1;
            end
            if (upd_dc && have_s1_q && d_s1 > max_delay_q) begin
                max_delay_q <= d_s1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Cycle supervision
    // ------------------------------------------------------------------
    logic cyc_start;
    logic busy_q;
    logic sm_seen_q;
    logic late_q;

    assign cyc_start = distributed_clock_mode ? evt.sync0 : evt.sm;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
        end else if (ce) begin
            busy_q <= cyc_start | (busy_q & ~evt.out_drive);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sm_seen_q <= 1'b0;
        end else if (ce) begin
            sm_seen_q <= evt.sync0 ? evt.sm : (sm_seen_q | evt.sm);
        end
    end

    // Judged at each SYNC0 in distributed-clock mode: were the previous outputs out in time
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            late_q <= 1'b0;
        end else if (ce && distributed_clock_mode && evt.sync0) begin
            late_q <= busy_q & ~evt.out_drive;
        end
    end

    // ------------------------------------------------------------------
    // Saturating event counters
    // ------------------------------------------------------------------
    logic [2:0]  cnt_inc;
    logic [15:0] cnt_q [3];

    assign cnt_inc[0] = distributed_clock_mode && run_state &&
                        evt.sync0 && !sm_seen_q && !evt.sm;
    assign cnt_inc[1] = run_state && cyc_start && busy_q &&
                        !evt.out_drive;
    assign cnt_inc[2] = distributed_clock_mode && evt.sync1 &&
                        have_s0_q && d_s0 < calc_copy_q;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cnt
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    cnt_q[gi] <= 16'h0;
                end else if (ce && cnt_inc[gi] &&
                             cnt_q[gi] != `STM_CNT_MAX) begin
                    cnt_q[gi] <= cnt_q[gi] + `STM_CNT_ONE;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Object reads and answer
    // ------------------------------------------------------------------
    logic [31:0] rd_data;
    logic        rd_hit;
    logic        wr_ok;

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0;
        case (addr)
            {`STM_IDX_OUT, `STM_SUB_SHIFT}:     rd_data = shift_out_q;
            {`STM_IDX_OUT, `STM_SUB_MIN_CYCLE}: rd_data = `STM_MIN_CYCLE_NS;
            {`STM_IDX_OUT, `STM_SUB_CALC_COPY}: rd_data = calc_copy_q;
            {`STM_IDX_OUT, `STM_SUB_MIN_DELAY}: rd_data = min_delay_q;
            {`STM_IDX_OUT, `STM_SUB_COMMAND}:   rd_data = {16'h0, cmd_q};
            {`STM_IDX_OUT, `STM_SUB_MAX_DELAY}: rd_data = max_delay_q;
            {`STM_IDX_OUT, `STM_SUB_MISSED}:    rd_data = {16'h0, cnt_q[0]};
            {`STM_IDX_OUT, `STM_SUB_OVERRUN}:   rd_data = {16'h0, cnt_q[1]};
            {`STM_IDX_OUT, `STM_SUB_SHORT}:     rd_data = {16'h0, cnt_q[2]};
            {`STM_IDX_OUT, `STM_SUB_LATE}:      rd_data = {31'h0, late_q};
            {`STM_IDX_IN, `STM_SUB_COUNT}:
                rd_data = {24'h0, `STM_IN_PARAM_CNT};
            {`STM_IDX_IN, `STM_SUB_MODE}:       rd_data = {16'h0, in_mode_q};
            {`STM_IDX_IN, `STM_SUB_CYCLE}:      rd_data = in_cycle_q;
            default:                            rd_hit  = 1'b0;
        endcase
    end

    assign wr_ok = wr_cmd || wr_cycle || (wr_mode && mode_ok);

    // Write wins when both strobes are raised together
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_q <= '0;
        end else if (ce) begin
            rsp_q.ack <= req.rd | req.wr;
            rsp_q.err <= req.wr ? ~wr_ok : (req.rd & ~rd_hit);
            if (req.rd && !req.wr) begin
                rsp_q.rdata <= rd_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_rd_min_cycle;
        ce && req.rd && !req.wr && addr == {`STM_IDX_OUT, `STM_SUB_MIN_CYCLE};
    endsequence

    property p_min_cycle;
        s_rd_min_cycle |=> rsp_q.ack && rsp_q.rdata == 32'd66000;
    endproperty
    a_min_cycle: assert property (p_min_cycle)
        else $error("minimum cycle time read wrong");

    sequence s_start;
        start;
    endsequence

    property p_start_clears;
        s_start |=> max_delay_q == 32'h0 && calc_copy_q == 32'h0
                    && measuring;
    endproperty
    a_start_clears: assert property (p_start_clears)
        else $error("start did not clear maxima");

    property p_stop;
        ce && wr_cmd && req.wdata[15:0] == `STM_CMD_RST |=> !measuring;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not end measurement");

    property p_max_grows;
        ce && upd_dc && have_s1_q && !start && d_s1 > max_delay_q
            |=> max_delay_q == $past(d_s1);
    endproperty
    a_max_grows: assert property (p_max_grows)
        else $error("maximum delay not captured");

    property p_missed;
        ce && cnt_inc[0] && cnt_q[0] != `STM_CNT_MAX
            |=> cnt_q[0] == $past(cnt_q[0]) + 16'h1;
    endproperty
    a_missed: assert property (p_missed)
        else $error("missed event not counted");

    property p_overrun;
        ce && run_state && cyc_start && busy_q && !evt.out_drive
            && cnt_q[1] != `STM_CNT_MAX
            |=> cnt_q[1] == $past(cnt_q[1]) + 16'h1;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not counted");

    property p_short;
        ce && cnt_inc[2] && cnt_q[2] != `STM_CNT_MAX
            |=> cnt_q[2] == $past(cnt_q[2]) + 16'h1;
    endproperty
    a_short: assert property (p_short)
        else $error("short shift not counted");

    property p_late;
        ce && distributed_clock_mode && evt.sync0
            |=> late_q == $past(busy_q && !evt.out_drive);
    endproperty
    a_late: assert property (p_late)
        else $error("late output flag wrong");

    property p_mode_keep;
        ce && wr_mode && !mode_ok |=> in_mode_q == $past(in_mode_q)
                                      && rsp_q.err;
    endproperty
    a_mode_keep: assert property (p_mode_keep)
        else $error("illegal sync mode accepted");

    property p_saturate;
        cnt_q[1] == `STM_CNT_MAX |=> cnt_q[1] == `STM_CNT_MAX;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("counter wrapped");

endmodule : stm_monitor

// file: design/stm_pkg.sv
// Types shared by the timing monitor
package stm_pkg;

    // Timing events from the local process-data logic, one-cycle pulses
    typedef struct packed {
        logic sync0;
        logic sync1;
        logic sm;
        logic out_drive;
    } stm_evt_t;

    // Object access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [31:0] wdata;
    } stm_req_t;

    // Object access answer
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } stm_rsp_t;

    typedef enum logic [0:0] {
        STM_IDLE    = 1'b0,
        STM_MEASURE = 1'b1
    } stm_meas_t;

endpackage : stm_pkg

// file: verif/stm_master.sv
// Object-access master model facing the timing monitor
`timescale 1ns/1ps
`include "stm_consts.svh"

module stm_master (
    // Clock
    input  wire logic              core_clk,
    // Object access
    output stm_pkg::stm_req_t      req,
    input  wire stm_pkg::stm_rsp_t rsp_q
);
    import stm_pkg::*;

    initial req = '0;

    // ------------------------------------------------------------------
    // One access
    // ------------------------------------------------------------------
    // Request held over its taking edge; the answer stands one cycle
    task xfer(input logic wr, input logic [15:0] idx,
              input logic [7:0] sub, input logic [31:0] wd,
              output logic ack, output logic err, output logic [31:0] rd);
        @(negedge core_clk);
        req.rd    = !wr;
        req.wr    = wr;
        req.index = idx;
        req.sub   = sub;
        req.wdata = wd;
        @(negedge core_clk);
        ack = rsp_q.ack;
        err = rsp_q.err;
        rd  = rsp_q.rdata;
        // Released fields show the inverse, so stale values cannot match
        req.rd    = 1'b0;
        req.wr    = 1'b0;
        req.index = ~idx;
        req.sub   = ~sub;
        req.wdata = ~wd;
    endtask : xfer
endmodule : stm_master

// file: verif/tb.sv
// Self-checking bench for the synchronisation timing monitor
`timescale 1ns/1ps
`include "stm_consts.svh"

module tb;
    import stm_pkg::*;

    logic        core_clk, rst_b, ce, run_state, distributed_clock_mode;
    logic        measuring, ack, err;
    logic [31:0] rd;
    stm_evt_t    evt;
    stm_req_t    req;
    stm_rsp_t    rsp_q;
    int          failures, num_checks, cycles;
    logic [15:0] modes [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003,
                               16'h0022};

    stm_monitor u_stm_monitor (.core_clk(core_clk), .rst_b(rst_b),
        .ce(ce), .run_state(run_state),
        .distributed_clock_mode(distributed_clock_mode), .evt(evt),
        .req(req), .rsp_q(rsp_q), .measuring(measuring));
    stm_master u_stm_master (.core_clk(core_clk), .req(req), .rsp_q(rsp_q));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    task rdo(input logic [7:0] sub, input logic [31:0] exp,
             input logic eerr = 1'b0, input logic [15:0] idx = `STM_IDX_OUT);
        u_stm_master.xfer(1'b0, idx, sub, 32'h0, ack, err, rd);
        check(ack === 1'b1 && err === eerr && rd === exp, "read");
    endtask : rdo

    task wro(input logic [15:0] idx, input logic [7:0] sub,
             input logic [31:0] wd, input logic eerr);
        u_stm_master.xfer(1'b1, idx, sub, wd, ack, err, rd);
        check(ack === 1'b1 && err === eerr, "write answer");
    endtask : wro

    // Event pulse for one cycle, then n idle cycles
    task ev(input logic [3:0] e, input int n);
        @(negedge core_clk);
        evt = e;
        @(negedge core_clk);
        evt = '0;
        repeat (n) @(negedge core_clk);
    endtask : ev

    // sync0, sm two cycles on, sync1 at 5, out_drive at 5 + 2 + d
    task round(input int d);
        ev(4'h8, 0);
        ev(4'h2, 1);
        ev(4'h4, d);
        ev(4'h1, 2);
    endtask : round

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Hang guard; counter saturation alone holds an event 65540 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 70000) begin
            failures++;
            results;
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        run_state = 1'b0;
        distributed_clock_mode = 1'b0;
        evt = '0;
        repeat (12) @(negedge core_clk);
        rst_b = 1'b1;
        rdo(`STM_SUB_MIN_CYCLE, 32'h000101d0);
        rdo(`STM_SUB_CALC_COPY, 32'h0);
        rdo(`STM_SUB_MIN_DELAY, 32'h0);
        rdo(`STM_SUB_COMMAND, 32'h0);
        rdo(`STM_SUB_MAX_DELAY, 32'h0);
        rdo(`STM_SUB_MISSED, 32'h0);
        rdo(`STM_SUB_OVERRUN, 32'h0);
        rdo(`STM_SUB_SHORT, 32'h0);
        rdo(`STM_SUB_LATE, 32'h0);
        rdo(`STM_SUB_COUNT, 32'h20, 1'b0, `STM_IDX_IN);
        rdo(`STM_SUB_MODE, 32'h22, 1'b0, `STM_IDX_IN);
        rdo(`STM_SUB_CYCLE, 32'h000f4240, 1'b0, `STM_IDX_IN);
        wro(`STM_IDX_OUT, `STM_SUB_MIN_CYCLE, 32'h5, 1'b1);
        rdo(`STM_SUB_MIN_CYCLE, 32'h000101d0);
        rdo(8'h08, 32'h0, 1'b1, `STM_IDX_IN);
        foreach (modes[i]) begin
            wro(`STM_IDX_IN, `STM_SUB_MODE, {16'h0, modes[i]}, 1'b0);
            rdo(`STM_SUB_MODE, {16'h0, modes[i]}, 1'b0, `STM_IDX_IN);
        end
        wro(`STM_IDX_IN, `STM_SUB_MODE, 32'h5, 1'b1);
        rdo(`STM_SUB_MODE, 32'h22, 1'b0, `STM_IDX_IN);
        wro(`STM_IDX_IN, `STM_SUB_CYCLE, 32'h000186a0, 1'b0);
        rdo(`STM_SUB_CYCLE, 32'h000186a0, 1'b0, `STM_IDX_IN);
        // Measurement in distributed-clock mode, run state off
        distributed_clock_mode = 1'b1;
        wro(`STM_IDX_OUT, `STM_SUB_COMMAND, 32'h1, 1'b0);
        check(measuring === 1'b1, "measuring on");
        round(2);
        round(0);
        rdo(`STM_SUB_SHIFT, 32'd360);
        rdo(`STM_SUB_CALC_COPY, 32'd280);
        rdo(`STM_SUB_MAX_DELAY, 32'd160);
        rdo(`STM_SUB_MIN_DELAY, 32'd80);
        rdo(`STM_SUB_SHORT, 32'h1);
        wro(`STM_IDX_OUT, `STM_SUB_COMMAND, 32'h0, 1'b0);
        check(measuring === 1'b0, "measuring off");
        round(5);
        rdo(`STM_SUB_SHIFT, 32'd360);
        wro(`STM_IDX_OUT, `STM_SUB_COMMAND, 32'h1, 1'b0);
        rdo(`STM_SUB_SHIFT, 32'h0);
        rdo(`STM_SUB_CALC_COPY, 32'h0);
        rdo(`STM_SUB_MAX_DELAY, 32'h0);
        // Run-state counters
        run_state = 1'b1;
        ev(4'h8, 1);
        ev(4'h8, 1);
        rdo(`STM_SUB_MISSED, 32'h1);
        rdo(`STM_SUB_OVERRUN, 32'h1);
        rdo(`STM_SUB_LATE, 32'h1);
        ev(4'h2, 0);
        ev(4'h1, 0);
        ev(4'h8, 1);
        rdo(`STM_SUB_LATE, 32'h0);
        rdo(`STM_SUB_MISSED, 32'h1);
        ev(4'h1, 0);
        distributed_clock_mode = 1'b0;
        ev(4'h2, 1);
        ev(4'h2, 1);
        ev(4'h8, 1);
        ev(4'h8, 1);
        rdo(`STM_SUB_OVERRUN, 32'h2);
        rdo(`STM_SUB_MISSED, 32'h1);
        rdo(`STM_SUB_LATE, 32'h0);
        run_state = 1'b0;
        distributed_clock_mode = 1'b1;
        ev(4'h8, 1);
        ev(4'h8, 1);
        rdo(`STM_SUB_MISSED, 32'h1);
        rdo(`STM_SUB_OVERRUN, 32'h2);
        // Second reset in mid-run
        @(negedge core_clk);
        rst_b = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        rdo(`STM_SUB_MISSED, 32'h0);
        rdo(`STM_SUB_OVERRUN, 32'h0);
        rdo(`STM_SUB_SHORT, 32'h0);
        rdo(`STM_SUB_MODE, 32'h22, 1'b0, `STM_IDX_IN);
        rdo(`STM_SUB_CYCLE, 32'h000f4240, 1'b0, `STM_IDX_IN);
        rdo(`STM_SUB_LATE, 32'h0);
        check(measuring === 1'b0, "measuring after reset");
        // Clock enable low: sync0 without sm in run state must not count
        run_state = 1'b1;
        ce = 1'b0;
        ev(4'h8, 1);
        ev(4'h8, 1);
        ce = 1'b1;
        run_state = 1'b0;
        rdo(`STM_SUB_MISSED, 32'h0);
        rdo(`STM_SUB_OVERRUN, 32'h0);
        // Back-to-back sync0 in run state drives both counters to the top
        run_state = 1'b1;
        @(negedge core_clk);
        evt = 4'h8;
        repeat (65540) @(negedge core_clk);
        evt = '0;
        run_state = 1'b0;
        rdo(`STM_SUB_OVERRUN, 32'h0000ffff);
        rdo(`STM_SUB_MISSED, 32'h0000ffff);
        results;
    end
endmodule : tb
